// *** verilog/mss_pkg.sv ***
// Package: register map, field layouts and timing for the motor start sequencer
package mss_pkg;
	// Register byte offsets
	localparam logic [7:0] CFG_ENABLE_OFS = 8'h00;
	localparam logic [7:0] CFG_THRESH_OFS = 8'h04;
	localparam logic [7:0] CFG_ACCEL_OFS = 8'h08;
	localparam logic [7:0] STATUS_OFS = 8'h0C;
	localparam logic [7:0] POSITION_OFS = 8'h10;
	// CFG_ENABLE fields
	localparam int EN_SPEED_DETECT_BIT = 0;
	localparam int EN_REVERSE_DRIVE_BIT = 1;
	localparam int EN_RELEASE_MODE_BIT = 2;
	localparam int EN_STANDBY_BIT = 3;
	localparam int EN_ADVANCE_LSB = 4;
	localparam int EN_OLCURR_LSB = 6;
	localparam int EN_ALIGN_LSB = 8;
	localparam int EN_BRKDONE_LSB = 12;
	localparam int EN_BRKCUR_LSB = 16;
	localparam int EN_PDCUR_LSB = 20;
	// CFG_THRESH fields
	localparam int TH_STATIONARY_LSB = 0;
	localparam int TH_REVERSE_LSB = 2;
	localparam int TH_OPEN_CLOSED_LSB = 4;
	localparam int TH_PULSE_RATE_LSB = 12;
	// CFG_ACCEL fields
	localparam int AC_FIRST_LSB = 0;
	localparam int AC_SECOND_LSB = 4;
	// Reset values
	localparam logic [31:0] CFG_ENABLE_RST = 32'h0011_1001;
	localparam logic [31:0] CFG_THRESH_RST = 32'h0000_0105;
	localparam logic [31:0] CFG_ACCEL_RST = 32'h0000_0033;
	// Timing: base tick 1 ms at 20 MHz
	localparam int CLK_HZ = 20_000_000;
	localparam int TICK_US = 1000;
	localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
	// State encodings (one-hot)
	typedef enum logic [11:0] {
		MSS_POWER_ON = 12'h001,
		MSS_SPEED_DETECT = 12'h002,
		MSS_DIRECTION = 12'h004,
		MSS_REVERSE_CHECK = 12'h008,
		MSS_REVERSE_DRIVE = 12'h010,
		MSS_BRAKE_CHECK = 12'h020,
		MSS_BRAKE = 12'h040,
		MSS_PD_CHECK = 12'h080,
		MSS_ALIGN = 12'h100,
		MSS_POS_DETECT = 12'h200,
		MSS_ACCEL = 12'h400,
		MSS_CLOSED = 12'h800
	} mss_state_t;
endpackage : mss_pkg

// *** verilog/mss_start_sequencer.sv ***
// Motor start sequencer with APB register file and phase drive control
// Overview of operation
// [R1] Start in power-on state at reset or standby exit, then check speed detect.
// [R2] Speed-detect enable 1 enters speed detect; else go to brake decision.
// [R3] Speed below stationary threshold goes to brake decision; above to direction.
// [R4] Forward loads measured speed and position, enters closed loop; reverse checks.
// [R5] Reverse speed above threshold returns to speed detect; below goes on.
// [R6] Reverse-drive enable 1 enters reverse drive; else brake decision. Code enters reverse drive anyway; enable 0 then leaves for brake check.
// [R7] Reverse drive pushes forward until zero speed, then accelerate.
// [R8] Nonzero brake-done time enables brake; else start as stationary.
// [R9] Brake turns on all three low-side switches together.
// [R10] Leave brake after current stays low for brake-done time; then position check.
// [R11] Nonzero position-detect current threshold selects detect; zero selects align.
// [R12] Align drives current into V out of W for align time at open-loop current.
// [R13] Position detect pulses VW,WV,UV,VU,WU,UW, timing each to current threshold.
// [R14] Fastest pulse gives rotor position; then accelerate.
// [R15] Release mode 0 keeps low side on; 1 turns all switches off.
// [R16] Drive starts at advance-angle offset from detected state.
// [R17] Accelerate with first and second order coefficients until open-to-closed threshold.
// [R18] Closed loop takes drive state from commutation feedback.
// [R19] Direction input change stops drive and restarts sequencer.
// [R20] Speed detect keeps phases high impedance while comparators observe.
// [R21] UW lagging UV by 60 degrees is forward; leading is reverse.
// [R22] Speed is rising-edge interval; no toggle for stationary time is stationary.
module mss_start_sequencer (
	input wire logic clk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic dir_in,
	input wire logic cmp_uv,
	input wire logic cmp_uw,
	input wire logic cur_above_brake,
	input wire logic cur_above_pd,
	input wire logic [2:0] fb_drive_state,
	output logic [2:0] high_on,
	output logic [2:0] low_on,
	output logic [1:0] current_level,
	output logic [2:0] drive_state,
	output logic closed_loop
);
	logic [31:0] cfg_en_r, cfg_th_r, cfg_ac_r;
	mss_pkg::mss_state_t state_r, state_nxt;
	logic [2:0] dir_s_r, uv_s_r, uw_s_r, cb_s_r, cp_s_r;
	logic [14:0] tick_cnt_r;
	logic tick;
	logic [15:0] tcnt_r, period_r, best_r;
	logic [2:0] pd_idx_r, best_idx_r, pos_r, drive_r;
	logic pd_on_r, fwd_r;
	logic [15:0] rate_r, inc_r;
	logic standby_d_r;
	logic [2:0] hi_r, lo_r;
	logic [2:0] pd_lo_last_r, step_hi, step_lo;

	// Register fields
	wire sd_en = cfg_en_r[mss_pkg::EN_SPEED_DETECT_BIT];
	wire rd_en = cfg_en_r[mss_pkg::EN_REVERSE_DRIVE_BIT];
	wire rel_md = cfg_en_r[mss_pkg::EN_RELEASE_MODE_BIT];
	wire standby = cfg_en_r[mss_pkg::EN_STANDBY_BIT];
	wire [1:0] adv = cfg_en_r[mss_pkg::EN_ADVANCE_LSB +: 2];
	wire [1:0] olcurr = cfg_en_r[mss_pkg::EN_OLCURR_LSB +: 2];
	wire [2:0] align_t = cfg_en_r[mss_pkg::EN_ALIGN_LSB +: 3];
	wire [2:0] brk_t = cfg_en_r[mss_pkg::EN_BRKDONE_LSB +: 3];
	wire [3:0] pd_cur = cfg_en_r[mss_pkg::EN_PDCUR_LSB +: 4];
	wire [1:0] stat_th = cfg_th_r[mss_pkg::TH_STATIONARY_LSB +: 2];
	wire [1:0] rev_th = cfg_th_r[mss_pkg::TH_REVERSE_LSB +: 2];
	wire [7:0] oc_th = cfg_th_r[mss_pkg::TH_OPEN_CLOSED_LSB +: 8];
	wire [1:0] pulse_rt = cfg_th_r[mss_pkg::TH_PULSE_RATE_LSB +: 2];
	wire [2:0] acc1 = cfg_ac_r[mss_pkg::AC_FIRST_LSB +: 3];
	wire [2:0] acc2 = cfg_ac_r[mss_pkg::AC_SECOND_LSB +: 3];

	// APB decode; zero-wait answer, error on unmapped address
	wire hit_en = paddr == mss_pkg::CFG_ENABLE_OFS;
	wire hit_th = paddr == mss_pkg::CFG_THRESH_OFS;
	wire hit_ac = paddr == mss_pkg::CFG_ACCEL_OFS;
	wire hit_st = paddr == mss_pkg::STATUS_OFS;
	wire hit_po = paddr == mss_pkg::POSITION_OFS;
	wire mapped = hit_en | hit_th | hit_ac | hit_st | hit_po;
	wire wr = psel & penable & pwrite & mapped;
	assign pready = psel & penable;
	assign pslverr = psel & penable & ~mapped;
	wire [31:0] rd_mux = hit_en ? cfg_en_r : hit_th ? cfg_th_r :
		hit_ac ? cfg_ac_r :
		hit_st ? {19'h0, closed_loop, state_r} :
		hit_po ? {8'h0, rate_r, 1'b0, fwd_r, pos_r, drive_r} : 32'h0;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cfg_en_r <= mss_pkg::CFG_ENABLE_RST;
			cfg_th_r <= mss_pkg::CFG_THRESH_RST;
			cfg_ac_r <= mss_pkg::CFG_ACCEL_RST;
			prdata <= 32'h0;
		end else begin
			if (wr & hit_en) cfg_en_r <= pwdata;
			if (wr & hit_th) cfg_th_r <= pwdata;
			if (wr & hit_ac) cfg_ac_r <= pwdata;
			if (psel & ~penable & ~pwrite) prdata <= rd_mux;
		end
	end

	// Pin synchronisers; stage 0 only feeds stage 1
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			dir_s_r <= 3'h0;
			uv_s_r <= 3'h0;
			uw_s_r <= 3'h0;
			cb_s_r <= 3'h0;
			cp_s_r <= 3'h0;
		end else begin
			dir_s_r <= {dir_s_r[1:0], dir_in};
			uv_s_r <= {uv_s_r[1:0], cmp_uv};
			uw_s_r <= {uw_s_r[1:0], cmp_uw};
			cb_s_r <= {cb_s_r[1:0], cur_above_brake};
			cp_s_r <= {cp_s_r[1:0], cur_above_pd};
		end
	end
	wire dir_chg = dir_s_r[2] ^ dir_s_r[1]; // [R19]
	wire uv_rise = uv_s_r[1] & ~uv_s_r[2];
	wire uw_rise = uw_s_r[1] & ~uw_s_r[2];
	wire cur_hi_brk = cb_s_r[1];
	wire cur_hi_pd = cp_s_r[1];
	wire standby_exit = standby_d_r & ~standby; // [R1]

	// Millisecond tick for all state timers except the position-detect pulse timer, which counts clocks
	assign tick = tick_cnt_r == 15'(mss_pkg::TICK_CYCLES - 1);
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) tick_cnt_r <= 15'h0;
		else tick_cnt_r <= tick ? 15'h0 : tick_cnt_r + 15'h1;
	end

	// Timer limits in ticks, scaled from the small fields; pd_tmo is a fixed count of clocks
	wire [15:0] stat_lim = 16'h0010 << stat_th; // [R22]
	wire [15:0] rev_lim = 16'h0008 << rev_th;
	wire [15:0] align_lim = 16'h0028 << align_t;
	wire [15:0] brk_lim = 16'h0008 << brk_t;
	wire [15:0] pd_gap = 16'h0001 << pulse_rt;
	wire [15:0] pd_tmo = 16'h0040;
	// Each pulse is timed from its own start, so the timer clears at both ends
	wire pd_start = state_r == mss_pkg::MSS_POS_DETECT && !pd_on_r &&
		pd_idx_r != 3'd6 && tick && tcnt_r >= pd_gap;
	wire pd_stop = state_r == mss_pkg::MSS_POS_DETECT && pd_on_r &&
		(cur_hi_pd || tcnt_r >= pd_tmo);

	// Next-state logic
	wire t_stat = tcnt_r >= stat_lim;
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			mss_pkg::MSS_POWER_ON: state_nxt = sd_en ? // [R1] [R2]
				mss_pkg::MSS_SPEED_DETECT : mss_pkg::MSS_BRAKE_CHECK;
			mss_pkg::MSS_SPEED_DETECT: begin
				if (t_stat) state_nxt = mss_pkg::MSS_BRAKE_CHECK; // [R3] [R22]
				else if (period_r != 16'h0 && period_r < stat_lim)
					state_nxt = mss_pkg::MSS_DIRECTION; // [R3]
			end
			mss_pkg::MSS_DIRECTION: state_nxt = fwd_r ? // [R4]
				mss_pkg::MSS_CLOSED : mss_pkg::MSS_REVERSE_CHECK;
			mss_pkg::MSS_REVERSE_CHECK: state_nxt = period_r < rev_lim ? // [R5]
				mss_pkg::MSS_SPEED_DETECT : mss_pkg::MSS_REVERSE_DRIVE;
			mss_pkg::MSS_REVERSE_DRIVE: begin
				if (!rd_en) state_nxt = mss_pkg::MSS_BRAKE_CHECK; // [R6]
				else if (tcnt_r >= stat_lim)
					state_nxt = mss_pkg::MSS_ACCEL; // [R7]
			end
			mss_pkg::MSS_BRAKE_CHECK: state_nxt = brk_t != 3'h0 ? // [R8]
				mss_pkg::MSS_BRAKE : mss_pkg::MSS_PD_CHECK;
			mss_pkg::MSS_BRAKE: if (tcnt_r >= brk_lim)
				state_nxt = mss_pkg::MSS_PD_CHECK; // [R10]
			mss_pkg::MSS_PD_CHECK: state_nxt = pd_cur != 4'h0 ? // [R11]
				mss_pkg::MSS_POS_DETECT : mss_pkg::MSS_ALIGN;
			mss_pkg::MSS_ALIGN: if (tcnt_r >= align_lim)
				state_nxt = mss_pkg::MSS_ACCEL; // [R12]
			mss_pkg::MSS_POS_DETECT: if (pd_idx_r == 3'd6)
				state_nxt = mss_pkg::MSS_ACCEL; // [R14]
			mss_pkg::MSS_ACCEL: if (rate_r[15:8] > oc_th)
				state_nxt = mss_pkg::MSS_CLOSED; // [R17]
			mss_pkg::MSS_CLOSED: state_nxt = mss_pkg::MSS_CLOSED;
			default: state_nxt = mss_pkg::MSS_POWER_ON;
		endcase
		if (dir_chg || standby || standby_exit)
			state_nxt = mss_pkg::MSS_POWER_ON; // [R19] [R1]
	end
	wire entering = state_nxt != state_r;

	// Reverse drive with disabled enable falls through to brake decision
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_r <= mss_pkg::MSS_POWER_ON;
			standby_d_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			standby_d_r <= standby;
		end
	end

	// State timer in ticks, in clocks during a detect pulse; brake timer restarts while current is high
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) tcnt_r <= 16'h0;
		else if (entering) tcnt_r <= 16'h0;
		else if (state_r == mss_pkg::MSS_BRAKE && cur_hi_brk)
			tcnt_r <= 16'h0; // [R10]
		else if (state_r == mss_pkg::MSS_SPEED_DETECT && (uv_rise | uw_rise))
			tcnt_r <= 16'h0; // [R22]
		else if (state_r == mss_pkg::MSS_REVERSE_DRIVE && (uv_rise | uw_rise))
			tcnt_r <= 16'h0; // [R7]
		else if (pd_start || pd_stop)
			tcnt_r <= 16'h0; // [R13]
		else if (state_r == mss_pkg::MSS_POS_DETECT && pd_on_r)
			tcnt_r <= tcnt_r + 16'h1;
		else if (tick && tcnt_r != 16'hFFFF) tcnt_r <= tcnt_r + 16'h1;
	end

	// Speed detect: edge interval and phase order of the comparators
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			period_r <= 16'h0;
			fwd_r <= 1'b0;
		end else if (state_r == mss_pkg::MSS_POWER_ON) begin
			period_r <= 16'h0;
			fwd_r <= 1'b0;
		end else if (state_r == mss_pkg::MSS_SPEED_DETECT) begin
			if (uv_rise | uw_rise) period_r <= tcnt_r + 16'h1; // [R22]
			if (uw_rise) fwd_r <= uv_s_r[1]; // [R21]
		end
	end

	// Position detect: six timed pulses, shortest wins
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pd_idx_r <= 3'h0;
			pd_on_r <= 1'b0;
			best_r <= 16'hFFFF;
			best_idx_r <= 3'h0;
			pd_lo_last_r <= 3'h0;
		end else if (state_r != mss_pkg::MSS_POS_DETECT) begin
			pd_idx_r <= 3'h0;
			pd_on_r <= 1'b0;
			best_r <= 16'hFFFF;
			pd_lo_last_r <= 3'h0;
		end else if (pd_on_r) begin
			if (cur_hi_pd || tcnt_r >= pd_tmo) begin // [R13]
				pd_on_r <= 1'b0;
				// Recirculation must use the low side of the pulse just ended
				pd_lo_last_r <= pd_lo; // [R15]
				if (cur_hi_pd && tcnt_r < best_r) begin // [R14]
					best_r <= tcnt_r;
					best_idx_r <= pd_idx_r;
				end
				pd_idx_r <= pd_idx_r + 3'h1;
			end
		end else if (pd_idx_r != 3'd6 && tick && tcnt_r >= pd_gap) begin
			pd_on_r <= 1'b1;
		end
	end
	// Pulse pair order VW,WV,UV,VU,WU,UW as high/low phase masks
	logic [2:0] pd_hi, pd_lo;
	always_comb begin
		case (pd_idx_r) // [R13]
			3'd0: begin pd_hi = 3'b010; pd_lo = 3'b100; end
			3'd1: begin pd_hi = 3'b100; pd_lo = 3'b010; end
			3'd2: begin pd_hi = 3'b001; pd_lo = 3'b010; end
			3'd3: begin pd_hi = 3'b010; pd_lo = 3'b001; end
			3'd4: begin pd_hi = 3'b100; pd_lo = 3'b001; end
			3'd5: begin pd_hi = 3'b001; pd_lo = 3'b100; end
			default: begin pd_hi = 3'b000; pd_lo = 3'b000; end
		endcase
	end

	// Six-step table; high and low side never share a phase
	always_comb begin
		case (drive_r)
			3'd0: begin step_hi = 3'b001; step_lo = 3'b010; end
			3'd1: begin step_hi = 3'b001; step_lo = 3'b100; end
			3'd2: begin step_hi = 3'b010; step_lo = 3'b100; end
			3'd3: begin step_hi = 3'b010; step_lo = 3'b001; end
			3'd4: begin step_hi = 3'b100; step_lo = 3'b001; end
			3'd5: begin step_hi = 3'b100; step_lo = 3'b010; end
			default: begin step_hi = 3'b000; step_lo = 3'b000; end
		endcase
	end

	// Detected position with advance offset applied
	wire [3:0] adv_sum = {1'b0, best_idx_r} + {2'b0, adv};
	wire [2:0] start_pos = adv_sum >= 4'd6 ? 3'(adv_sum - 4'd6) :
		adv_sum[2:0]; // [R16]

	// Open-loop ramp: rate grows by first order step plus growing second term
	wire [15:0] step = 16'h0001 << acc1;
	wire [15:0] jerk = 16'h0001 << acc2;
	wire [16:0] rate_sum = {1'b0, rate_r} + {1'b0, inc_r};
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rate_r <= 16'h0;
			inc_r <= 16'h0;
			drive_r <= 3'h0;
			pos_r <= 3'h0;
		end else begin
			if (state_r == mss_pkg::MSS_ACCEL && tick) begin // [R17]
				rate_r <= rate_sum[16] ? 16'hFFFF : rate_sum[15:0];
				inc_r <= inc_r + jerk;
				drive_r <= drive_r == 3'd5 ? 3'h0 : drive_r + 3'h1;
			end else if (state_r == mss_pkg::MSS_CLOSED) begin
				drive_r <= fb_drive_state; // [R18]
			end else if (state_r == mss_pkg::MSS_DIRECTION && fwd_r) begin
				rate_r <= 16'hFFFF - period_r; // [R4]
				drive_r <= {1'b0, uw_s_r[2], uv_s_r[2]};
				pos_r <= {1'b0, uw_s_r[2], uv_s_r[2]};
			end else if (state_nxt == mss_pkg::MSS_ACCEL && entering) begin
				rate_r <= 16'h0;
				inc_r <= step;
				if (state_r == mss_pkg::MSS_POS_DETECT) begin
					drive_r <= start_pos; // [R16]
					pos_r <= best_idx_r;
				end else drive_r <= 3'h0; // Aligned position
			end else if (state_r == mss_pkg::MSS_POWER_ON) begin
				rate_r <= 16'h0;
				inc_r <= 16'h0;
			end
		end
	end

	// Phase switch outputs by state; drive table limited to six steps
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			hi_r <= 3'h0;
			lo_r <= 3'h0;
		end else begin
			hi_r <= 3'h0;
			lo_r <= 3'h0;
			case (state_nxt)
				mss_pkg::MSS_BRAKE: lo_r <= 3'b111; // [R9]
				mss_pkg::MSS_ALIGN: begin
					hi_r <= 3'b010; // [R12]
					lo_r <= 3'b100;
				end
				mss_pkg::MSS_POS_DETECT: begin
					hi_r <= pd_on_r ? pd_hi : 3'h0;
					lo_r <= pd_on_r ? pd_lo :
						(rel_md ? 3'h0 : pd_lo_last_r); // [R15]
				end
				mss_pkg::MSS_REVERSE_DRIVE, mss_pkg::MSS_ACCEL,
				mss_pkg::MSS_CLOSED: begin
					hi_r <= step_hi;
					lo_r <= step_lo;
				end
				default: ; // [R20] Speed detect and idle leave phases floating
			endcase
		end
	end
	assign high_on = hi_r;
	assign low_on = lo_r;
	assign current_level = olcurr; // [R12]
	assign drive_state = drive_r;
	assign closed_loop = state_r == mss_pkg::MSS_CLOSED;
endmodule : mss_start_sequencer

// *** bench/mss_seq_asserts.sv ***
// Port-level checker for the motor start sequencer
module mss_seq_asserts (
	input wire logic clk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [7:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic dir_in,
	input wire logic [2:0] high_on,
	input wire logic [2:0] low_on
);
	logic mapped;
	assign mapped = paddr <= 8'h10 && paddr[1:0] == 2'h0;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence access_s;
		psel && penable;
	endsequence
	sequence dir_flip_s;
		$changed(dir_in);
	endsequence
	sequence drive_off_s;
		high_on == 3'h0 && low_on == 3'h0;
	endsequence
	a_ready_zero_wait: assert property (access_s |-> pready)
		else $error("pready missing in access phase");
	a_ready_idle_low: assert property (!(psel && penable) |-> !pready)
		else $error("pready outside access phase");
	a_err_unmapped: assert property (access_s and paddr > 8'h10 |-> pslverr)
		else $error("no error on unmapped address");
	a_err_mapped_clear: assert property (access_s and mapped |-> !pslverr)
		else $error("error on mapped address");
	a_err_access_only: assert property (pslverr |-> psel && penable)
		else $error("pslverr outside access phase");
	a_brake_low_all: assert property (low_on == 3'h7 |-> high_on == 3'h0)
		else $error("high side on while all low sides on");
	a_high_has_return: assert property (high_on != 3'h0 |-> low_on != 3'h0)
		else $error("high side driven with no return path");
	a_no_shoot_through: assert property ((high_on & low_on) == 3'h0)
		else $error("high and low side on in one phase");
	a_dir_stops_drive: assert property (dir_flip_s |-> ##[1:8] drive_off_s)
		else $error("drive not stopped after direction change");
endmodule : mss_seq_asserts

bind mss_start_sequencer mss_seq_asserts u_asserts (
	.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
	.paddr(paddr), .pready(pready), .pslverr(pslverr),
	.dir_in(dir_in), .high_on(high_on), .low_on(low_on)
);

// *** bench/mss_motor_model.sv ***
// Behavioural stationary motor seen through power stage and comparators
module mss_motor_model #(
	parameter int RISE = 12
) (
	input wire logic clk,
	input wire logic [2:0] high_on,
	input wire logic [2:0] low_on,
	output logic cmp_uv,
	output logic cmp_uw,
	output logic cur_above_brake,
	output logic cur_above_pd
);
	logic [7:0] amps_r = 8'h00;
	logic [7:0] amps_nxt;
	logic driven;
	// Winding current builds only while a high and a low switch conduct
	assign driven = |high_on && |low_on;
	assign amps_nxt = !driven ? 8'h00 : amps_r + {7'h00, amps_r != 8'hFF};
	always @(posedge clk) amps_r <= amps_nxt;
	assign cur_above_pd = amps_r >= 8'(RISE);
	// Braked rotor keeps current high, so the brake never times out here
	assign cur_above_brake = low_on == 3'h7;
	// Rotor at rest: no back-EMF, so the comparators never toggle
	assign cmp_uv = 1'h0;
	assign cmp_uw = 1'h0;
endmodule : mss_motor_model

// *** bench/test_mss_start_sequencer.sv ***
// Self-checking bench for the motor start sequencer
module test_mss_start_sequencer;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic wr;
		logic [7:0] a;
		logic [31:0] d;
		logic [31:0] x;
		logic e;
	} mss_row_t;
	logic clk = 1'h0;
	logic rstn = 1'h0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic dir_in = 1'h0;
	logic [31:0] prdata, q;
	logic pready, pslverr, cmp_uv, cmp_uw, cur_brk, cur_pd, closed_loop, e;
	logic [2:0] high_on, low_on, drive_state;
	logic [1:0] current_level;
	int compares = 0;
	int miscompares = 0;
	mss_row_t rows [10] = '{
		'{1'h0, 8'h00, 32'h0, mss_pkg::CFG_ENABLE_RST, 1'h0},
		'{1'h0, 8'h04, 32'h0, mss_pkg::CFG_THRESH_RST, 1'h0},
		'{1'h0, 8'h08, 32'h0, mss_pkg::CFG_ACCEL_RST, 1'h0},
		'{1'h0, 8'h0C, 32'h0, 32'h2, 1'h0},
		'{1'h1, 8'h14, 32'h77, 32'h0, 1'h1},
		'{1'h0, 8'h14, 32'h0, 32'h0, 1'h1},
		'{1'h1, 8'h08, 32'h77, 32'h0, 1'h0},
		'{1'h0, 8'h08, 32'h0, 32'h77, 1'h0},
		'{1'h1, 8'h0C, 32'hFFFF_FFFF, 32'h0, 1'h0},
		'{1'h0, 8'h0C, 32'h0, 32'h2, 1'h0}
	};
	always #25 clk = ~clk;
	mss_start_sequencer u_mss_start_sequencer (
		.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.dir_in(dir_in), .cmp_uv(cmp_uv), .cmp_uw(cmp_uw),
		.cur_above_brake(cur_brk), .cur_above_pd(cur_pd),
		.fb_drive_state(3'h0), .high_on(high_on), .low_on(low_on),
		.current_level(current_level), .drive_state(drive_state),
		.closed_loop(closed_loop)
	);
	mss_motor_model u_mss_motor_model (
		.clk(clk), .high_on(high_on), .low_on(low_on),
		.cmp_uv(cmp_uv), .cmp_uw(cmp_uw),
		.cur_above_brake(cur_brk), .cur_above_pd(cur_pd)
	);
	task automatic give_verdict();
		$display("compares=%0d miscompares=%0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : give_verdict
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		int n;
		logic to;
		n = 0;
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'h1 && n < 20);
		q = prdata;
		e = pslverr;
		to = pready !== 1'h1;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge clk);
		if (to) begin
			miscompares++;
			give_verdict();
		end
	endtask : apb
	// Doubles as a check: a bound that runs out fails the compare
	task automatic wait_out(input logic [2:0] hi, input logic [2:0] lo);
		int n;
		n = 0;
		while (n < 45000 && !(high_on === hi && low_on === lo)) begin
			@(posedge clk);
			n++;
		end
		chk({26'h0, high_on, low_on}, {26'h0, hi, lo});
		if (n == 45000)
			give_verdict();
	endtask : wait_out
	task automatic restart(input logic [31:0] cfg);
		apb(1'h1, 8'h00, cfg | 32'h8);
		repeat (4) @(posedge clk);
		apb(1'h0, 8'h0C, 32'h0);
		chk(q, 32'(mss_pkg::MSS_POWER_ON));
		apb(1'h1, 8'h00, cfg);
	endtask : restart
	initial begin
		repeat (10) @(posedge clk);
		rstn <= 1'h1;
		repeat (5) @(posedge clk);
		foreach (rows[i]) begin
			apb(rows[i].wr, rows[i].a, rows[i].d);
			if (!rows[i].wr)
				chk(q, rows[i].x);
			chk({31'h0, e}, {31'h0, rows[i].e});
		end
		chk({26'h0, high_on, low_on}, 32'h0);
		restart(32'h0011_1000);
		wait_out(3'h0, 3'h7);
		apb(1'h0, 8'h0C, 32'h0);
		chk(q, 32'h40);
		repeat (300) @(posedge clk);
		wait_out(3'h0, 3'h7);
		apb(1'h1, 8'h00, 32'h0011_1001);
		dir_in <= 1'h1;
		wait_out(3'h0, 3'h0);
		repeat (10) @(posedge clk);
		apb(1'h0, 8'h0C, 32'h0);
		chk(q, 32'h2);
		// Two release modes of position detect, then align
		for (int k = 0; k < 3; k++) begin
			restart(k == 2 ? 32'hC0 : 32'h0010_0000 | (32'(k) << 2));
			wait_out(3'h2, 3'h4);
			apb(1'h0, 8'h0C, 32'h0);
			chk(q, k == 2 ? 32'h100 : 32'h200);
			if (k < 2)
				wait_out(3'h0, k == 0 ? 3'h4 : 3'h0);
		end
		chk({30'h0, current_level}, 32'h3);
		give_verdict();
	end
endmodule : test_mss_start_sequencer
